// *** design/o2_alarm_range.sv ***
`timescale 1ns/100ps
`include "o2_defs.svh"

module o2_alarm_range (
	// clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// classic wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// concentration samples
	input  wire logic        sample_i,
	input  wire logic [15:0] conc_i,
	// relays, energized high
	output logic             first_concentration_alarm_relay_o,
	output logic             second_concentration_alarm_relay_o,
	// analog output codes
	output logic [15:0]      conc_volt_o,
	output logic [15:0]      conc_curr_o,
	output logic [15:0]      range_id_volt_o,
	output logic [15:0]      range_id_curr_o
);

	////////////////////////////////////////////////////////////////////////////
	// functions

	// merge a write word into a register by byte lanes
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
	                                           input logic [31:0] new_v,
	                                           input logic [3:0]  sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction

	// linear map of the sample over [bottom, 100 %] onto the voltage code
	function automatic logic [15:0] scale_conc(input logic [15:0] conc,
	                                           input logic [15:0] bottom);
		logic [31:0] num;
		logic [15:0] span;
		logic [31:0] quo;
		num  = 32'h0;
		span = 16'h0;
		quo  = 32'h0;
		if (conc >= `CONC_FULL) begin
			scale_conc = `DAC_FULL; // R19
		end else if (conc <= bottom) begin
			scale_conc = 16'h0000; // R20
		end else begin
			span = `CONC_FULL - bottom;
			num  = 32'(conc - bottom) * 32'(`DAC_FULL); // R22
			quo  = num / 32'(span);
			scale_conc = quo[15:0];
		end
	endfunction

	// 4 mA offset plus four fifths of the voltage code
	function automatic logic [15:0] volt_to_curr(input logic [15:0] v);
		logic [17:0] part;
		part = (18'(v) << 2) / 18'd5;
		return 16'(`DAC_I_OFFSET) + part[15:0]; // R22
	endfunction

	// one register word selected by the byte address
	function automatic logic word_hit(input logic [7:0] adr,
	                                  input logic [7:0] offset);
		return adr == offset;
	endfunction

	// entry level of the next narrower range; the margin stops chatter at a bound
	function automatic logic [15:0] narrow_level(input logic [15:0] lower);
		return lower + `RANGE_HYST;
	endfunction

	// steady identification levels, one pair per range
	function automatic o2_pkg::analog_pair_t range_id_pair(input o2_pkg::range_sel_t r);
		o2_pkg::analog_pair_t p;
		case (r)
			o2_pkg::RANGE_MIDDLE: begin
				p = '{volt_code: `ID_V_MID, curr_code: `ID_I_MID};
			end
			o2_pkg::RANGE_NARROW: begin
				p = '{volt_code: `ID_V_HIGH, curr_code: `ID_I_HIGH};
			end
			// the wide range, and a stray code falls back to it
			default: begin
				p = '{volt_code: `ID_V_LOW, curr_code: `ID_I_LOW};
			end
		endcase
		return p;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// registers

	o2_pkg::range_mode_t  range_mode;
	o2_pkg::alarm_cfg_t   alarm_cfg [2];
	logic [15:0]          bound [3];
	logic [15:0]          conc_held;
	o2_pkg::range_sel_t   range_act;
	o2_pkg::range_sel_t   next_range;
	o2_pkg::range_sel_t   out_range;
	o2_pkg::analog_pair_t conc_out;
	o2_pkg::analog_pair_t id_out;
	logic [1:0]           alarm_active;
	logic [1:0]           relay;
	logic                 bounds_ok;
	logic                 req;
	logic                 wr;
	logic [31:0]          rd_word;
	logic [15:0]          bottom;
	logic [15:0]          next_volt;
	logic [15:0]          next_curr;
	logic [31:0]          status_word;
	logic                 ctrl_wr;
	logic [1:0]           alarm_wr;
	logic [2:0]           bound_wr;
	logic [31:0]          alarm_wr_word [2];
	logic [31:0]          bound_wr_word [3];

	// a write lands on the edge where the master sees ack, request still held
	assign req = cyc_i && stb_i;
	assign wr  = req && we_i && ack_o;

	// software is trusted to keep bounds rising; status only reports it
	assign bounds_ok = (bound[0] < bound[1]) && (bound[1] < bound[2]); // R13

	// per-register write strobes and lane-merged write words
	always_comb begin
		ctrl_wr = wr && word_hit(adr_i, `REG_CTRL) && sel_i[0];
		for (int a = 0; a < 2; a++) begin
			alarm_wr[a]      = wr && word_hit(adr_i, 8'(`REG_ALARM1_CFG + 4 * a));
			alarm_wr_word[a] = lane_merge({12'h0, alarm_cfg[a]}, dat_i, sel_i);
		end
		for (int r = 0; r < 3; r++) begin
			bound_wr[r]      = wr && word_hit(adr_i, 8'(`REG_BOUND_LOW + 4 * r));
			bound_wr_word[r] = lane_merge({16'h0, bound[r]}, dat_i, sel_i);
		end
	end

	// ack one cycle after the strobe, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else if (ce_i) begin
			ack_o <= req && !ack_o;
		end
	end

	// range mode, auto from reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			range_mode <= o2_pkg::AUTO_RANGE_MODE; // R14
		end else if (ce_i && ctrl_wr) begin
			range_mode <= o2_pkg::range_mode_t'(dat_i[1:0]);
		end
	end

	// five settings per alarm, one word each
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int a = 0; a < 2; a++) begin
				alarm_cfg[a] <= '{latching: 1'b0, deenergize_on_alarm_setting: 1'b0,
				                  defeat: 1'b0, dir_high: 1'b1,
				                  setpoint: `ALM_SETPOINT_RST}; // R9
			end
		end else if (ce_i) begin
			for (int a = 0; a < 2; a++) begin
				if (alarm_wr[a]) begin
					alarm_cfg[a] <= o2_pkg::alarm_cfg_t'(alarm_wr_word[a][19:0]); // R9 R10
				end
			end
		end
	end

	// lower bounds of the three ranges; the top is fixed at 100 %
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bound[0] <= `BOUND_LOW_RST; // R11
			bound[1] <= `BOUND_MID_RST;
			bound[2] <= `BOUND_HIGH_RST;
		end else if (ce_i) begin
			for (int r = 0; r < 3; r++) begin
				if (bound_wr[r]) begin
					bound[r] <= bound_wr_word[r][15:0]; // R12
				end
			end
		end
	end

	// live state for software; the range field is the one taken on the last sample
	assign status_word = {25'h0, bounds_ok, range_act, relay, alarm_active};

	// read mux; unmapped offsets read zero
	always_comb begin
		rd_word = 32'h0;
		case (adr_i)
			`REG_CTRL:       rd_word = {30'h0, range_mode};
			`REG_ALARM1_CFG: rd_word = {12'h0, alarm_cfg[0]};
			`REG_ALARM2_CFG: rd_word = {12'h0, alarm_cfg[1]};
			`REG_BOUND_LOW:  rd_word = {16'h0, bound[0]};
			`REG_BOUND_MID:  rd_word = {16'h0, bound[1]};
			`REG_BOUND_HIGH: rd_word = {16'h0, bound[2]};
			`REG_STATUS:     rd_word = status_word;
			`REG_CONC:       rd_word = {16'h0, conc_held}; // R21
			`REG_OUT_V:      rd_word = {range_id_volt_o, conc_volt_o};
			`REG_OUT_I:      rd_word = {range_id_curr_o, conc_curr_o};
			default:         rd_word = 32'h0;
		endcase
	end

	// read data registered alongside ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0;
		end else if (ce_i) begin
			dat_o <= (req && !we_i && !ack_o) ? rd_word : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// concentration alarms

	for (genvar a = 0; a < 2; a++) begin : g_alarm
		conc_alarm u_alarm (
			.clk_i    (clk_i),
			.rst_i    (rst_i),
			.ce_i     (ce_i),
			.sample_i (sample_i),
			.conc_i   (conc_i),
			.cfg_i    (alarm_cfg[a]),
			.active_o (alarm_active[a]),
			.relay_o  (relay[a])
		);
	end

	// relay coils straight from the registered alarm stages
	assign first_concentration_alarm_relay_o  = relay[0];
	assign second_concentration_alarm_relay_o = relay[1];

	////////////////////////////////////////////////////////////////////////////
	// range selection

	// full-precision copy of the last sample, never clamped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conc_held <= 16'h0;
		end else if (ce_i && sample_i) begin
			conc_held <= conc_i; // R21
		end
	end

	// one step per sample; the margin keeps the range from chattering
	always_comb begin
		next_range = range_act;
		case (range_act)
			o2_pkg::RANGE_WIDE: begin
				if (conc_i >= narrow_level(bound[1])) begin
					next_range = o2_pkg::RANGE_MIDDLE; // R16
				end
			end
			o2_pkg::RANGE_MIDDLE: begin
				if (conc_i < bound[1]) begin
					next_range = o2_pkg::RANGE_WIDE; // R15
				end else if (conc_i >= narrow_level(bound[2])) begin
					next_range = o2_pkg::RANGE_NARROW; // R16
				end
			end
			o2_pkg::RANGE_NARROW: begin
				if (conc_i < bound[2]) begin
					next_range = o2_pkg::RANGE_MIDDLE; // R15
				end
			end
			default: next_range = o2_pkg::RANGE_WIDE;
		endcase
	end

	// fixed modes override the auto tracker outright
	always_comb begin
		case (range_mode)
			o2_pkg::FIXED_WIDE_RANGE_MODE:   out_range = o2_pkg::RANGE_WIDE; // R18
			o2_pkg::FIXED_MIDDLE_RANGE_MODE: out_range = o2_pkg::RANGE_MIDDLE;
			o2_pkg::FIXED_NARROW_RANGE_MODE: out_range = o2_pkg::RANGE_NARROW;
			default:                         out_range = next_range; // R15 R16
		endcase
	end

	// active range latched per sample
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			range_act <= o2_pkg::RANGE_WIDE;
		end else if (ce_i && sample_i) begin
			range_act <= out_range; // R24
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// analog outputs

	// bottom of the range being entered, so the codes follow it in the same sample
	assign bottom    = bound[out_range];
	assign next_volt = scale_conc(conc_i, bottom);
	assign next_curr = volt_to_curr(next_volt);

	// concentration codes follow the newly chosen range in the same sample
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conc_out <= '{volt_code: 16'h0, curr_code: `DAC_I_OFFSET};
		end else if (ce_i && sample_i) begin
			conc_out.volt_code <= next_volt; // R17 R19 R20 R22
			conc_out.curr_code <= next_curr; // R22
		end
	end

	// range identification levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			id_out <= range_id_pair(o2_pkg::RANGE_WIDE);
		end else if (ce_i && sample_i) begin
			id_out <= range_id_pair(out_range); // R23 R17
		end
	end

	// registered codes go to the converters unchanged
	assign conc_volt_o     = conc_out.volt_code;
	assign conc_curr_o     = conc_out.curr_code;
	assign range_id_volt_o = id_out.volt_code;
	assign range_id_curr_o = id_out.curr_code;

endmodule

// *** design/o2_defs.svh ***
// Contract
// [R1] High-direction alarm asserts while concentration is above its setpoint.
// [R2] Low-direction alarm asserts while concentration is below its setpoint.
// [R3] Failsafe alarm de-energizes its relay when active; otherwise it energizes it.
// [R4] Latching alarm stays active after conditions clear, until explicitly reset.
// [R5] Non-latching alarm clears as soon as its trigger condition ends.
// [R6] Defeat suppresses the alarm; relay stays in its non-alarm state.
// [R7] Switching defeat on then off clears a latched alarm.
// [R8] Switching latching off then on clears a latched alarm.
// [R9] Each alarm holds setpoint, direction, defeat, failsafe and latching settings.
// [R10] Setpoints use the same percent-oxygen units as the measured concentration.
// [R11] Three ranges with programmable lower bounds, defaults 95, 96, 98 percent.
// [R12] Every range tops out at 100 percent; only lower bounds program.
// [R13] Software keeps lower bounds increasing from low to high range.
// [R14] Range selection comes out of reset in automatic mode.
// [R15] Automatic mode moves to the next wider range when leaving active limits.
// [R16] Automatic mode moves to the narrower range once just inside its limits.
// [R17] A range change updates the concentration and range identification outputs.
// [R18] Fixed mode holds the analog outputs on one chosen range.
// [R19] Concentration above the range top clamps the voltage output at full scale.
// [R20] Concentration below the range bottom drives the voltage output to zero.
// [R21] The full-precision concentration stays readable regardless of range or clamping.
// [R22] Output is linear: bottom gives 0 V and 4 mA, top 1 V and 20 mA.
// [R23] Range identification is 0.25/0.5/0.75 V or 8/12/16 mA per range.
// [R24] Alarms and range re-evaluate on every sample; changes apply from next sample.
`ifndef O2_DEFS_SVH
`define O2_DEFS_SVH

// register byte offsets
`define REG_CTRL        8'h00
`define REG_ALARM1_CFG  8'h04
`define REG_ALARM2_CFG  8'h08
`define REG_BOUND_LOW   8'h0c
`define REG_BOUND_MID   8'h10
`define REG_BOUND_HIGH  8'h14
`define REG_STATUS      8'h18
`define REG_CONC        8'h1c
`define REG_OUT_V       8'h20
`define REG_OUT_I       8'h24

// alarm config field positions
`define ALM_SETPOINT_LSB 0
`define ALM_DIR_HIGH_BIT 16
`define ALM_DEFEAT_BIT   17
`define ALM_FAILSAFE_BIT 18
`define ALM_LATCH_BIT    19

// concentration in hundredths of a percent
`define CONC_FULL        16'h2710
`define BOUND_LOW_RST    16'h251c
`define BOUND_MID_RST    16'h2580
`define BOUND_HIGH_RST   16'h2648
`define ALM_SETPOINT_RST 16'h2648
`define RANGE_HYST       16'h000a

// output codes, 16'hffff is 1 V or 20 mA
`define DAC_FULL         16'hffff
`define DAC_I_OFFSET     16'h3333
`define ID_V_LOW         16'h4000
`define ID_V_MID         16'h8000
`define ID_V_HIGH        16'hc000
`define ID_I_LOW         16'h6666
`define ID_I_MID         16'h9999
`define ID_I_HIGH        16'hcccc

`endif

// *** design/o2_pkg.sv ***
package o2_pkg;

	typedef enum logic [1:0] {
		RANGE_WIDE,
		RANGE_MIDDLE,
		RANGE_NARROW
	} range_sel_t;

	typedef enum logic [1:0] {
		AUTO_RANGE_MODE,
		FIXED_WIDE_RANGE_MODE,
		FIXED_MIDDLE_RANGE_MODE,
		FIXED_NARROW_RANGE_MODE
	} range_mode_t;

	typedef struct packed {
		logic        latching;
		logic        deenergize_on_alarm_setting;
		logic        defeat;
		logic        dir_high;
		logic [15:0] setpoint;
	} alarm_cfg_t;

	typedef struct packed {
		logic [15:0] volt_code;
		logic [15:0] curr_code;
	} analog_pair_t;

endpackage

// *** design/conc_alarm.sv ***
`timescale 1ns/100ps
`include "o2_defs.svh"

module conc_alarm (
	// clock, reset and enable
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	// sample and settings
	input  wire logic              sample_i,
	input  wire logic [15:0]       conc_i,
	input  wire o2_pkg::alarm_cfg_t cfg_i,
	// result
	output logic                   active_o,
	output logic                   relay_o
);

	logic prev_defeat;
	logic prev_latch;
	logic trigger;
	logic reset_latch;

	// direction compare in the same units as the sample
	assign trigger = cfg_i.dir_high ? (conc_i > cfg_i.setpoint)  // R1 R10
	                                : (conc_i < cfg_i.setpoint); // R2

	// defeat released or latching re-armed clears a held alarm
	assign reset_latch = (prev_defeat && !cfg_i.defeat)          // R7
	                   || (!prev_latch && cfg_i.latching);      // R8

	// previous settings, for the toggle-to-reset sequences
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_defeat <= 1'b0;
			prev_latch  <= 1'b0;
		end else if (ce_i) begin
			prev_defeat <= cfg_i.defeat;
			prev_latch  <= cfg_i.latching;
		end
	end

	// alarm state moves on a sample, save defeat and the clearing toggles, which act at once
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_o <= 1'b0;
		end else if (ce_i) begin
			if (cfg_i.defeat) begin
				active_o <= 1'b0; // R6
			end else if (sample_i) begin // R24
				// a trigger in the clearing cycle wins, so the clear drops only old state
				if (cfg_i.latching && !reset_latch) begin
					active_o <= active_o | trigger; // R4
				end else begin
					active_o <= trigger; // R5
				end
			end else if (reset_latch) begin
				active_o <= 1'b0; // R7 R8
			end
		end
	end

	// relay energized level; failsafe inverts so power loss reads as alarm
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			relay_o <= 1'b0;
		end else if (ce_i) begin
			relay_o <= cfg_i.deenergize_on_alarm_setting ? !active_o : active_o; // R3
		end
	end

endmodule

// *** tb/o2_output_stage.sv ***
`timescale 1ns/100ps
module o2_output_stage (
	// relay coils, energized high
	input  wire logic        relay1_i,
	input  wire logic        relay2_i,
	// dac codes
	input  wire logic [15:0] volt_code_i,
	input  wire logic [15:0] curr_code_i,
	input  wire logic [15:0] id_volt_code_i,
	input  wire logic [15:0] id_curr_code_i,
	// contacts, levels in mV and uA
	output logic [1:0]       contact_o,
	output logic [15:0]      volt_mv_o,
	output logic [15:0]      curr_ua_o,
	output logic [15:0]      id_mv_o,
	output logic [15:0]      id_ua_o
);
	// rounded so one lsb of dac error does not flip a level
	function automatic logic [15:0] scale(input logic [15:0] code, input logic [31:0] fs);
		return 16'((32'(code) * fs + 32'd32767) / 32'd65535);
	endfunction

	// normally-open contact closes while coil is energized
	assign contact_o = {relay2_i, relay1_i};
	// full code is 1 V or 20 mA
	assign volt_mv_o = scale(volt_code_i, 32'd1000);
	assign curr_ua_o = scale(curr_code_i, 32'd20000);
	assign id_mv_o   = scale(id_volt_code_i, 32'd1000);
	assign id_ua_o   = scale(id_curr_code_i, 32'd20000);
endmodule

// *** tb/o2_alarm_range_asserts.sv ***
`timescale 1ns/100ps
module o2_alarm_range_asserts (
	// watched ports
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        sample_i,
	input wire logic [15:0] conc_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        first_concentration_alarm_relay_o,
	input wire logic [15:0] conc_volt_o,
	input wire logic [15:0] conc_curr_o,
	input wire logic [15:0] range_id_volt_o,
	input wire logic [15:0] range_id_curr_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// request and sample steps
	sequence s_req;
		cyc_i && stb_i && !ack_o && ce_i;
	endsequence
	sequence s_sample;
		sample_i && ce_i;
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	ack_answer_a: assert property (s_req |=> ack_o) else $error("no ack after request");
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than a cycle");
	dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data not idle");
	curr_scale_a: assert property (conc_curr_o == 16'h3333 + 16'((32'(conc_volt_o) * 4) / 5))
		else $error("current code off the voltage line");
	id_pair_a: assert property ((range_id_volt_o == 16'h4000 && range_id_curr_o == 16'h6666)
		|| (range_id_volt_o == 16'h8000 && range_id_curr_o == 16'h9999)
		|| (range_id_volt_o == 16'hc000 && range_id_curr_o == 16'hcccc)) else $error("bad range id");
	full_clamp_a: assert property (s_sample ##0 (conc_i >= 16'h2710) |=> conc_volt_o == 16'hffff)
		else $error("no clamp at full scale");
	zero_clamp_a: assert property (s_sample ##0 (conc_i < 16'h251c) |=> conc_volt_o == 16'h0)
		else $error("no zero below range");
	hold_out_a: assert property (!(sample_i && ce_i) |=> $stable(conc_volt_o)
		&& $stable(range_id_volt_o)) else $error("output moved without sample");
	relay_cause_a: assert property (!$stable(first_concentration_alarm_relay_o)
		|-> $past(sample_i && ce_i, 2) || $past(ack_o) || $past(ack_o, 2) || $past(ack_o, 3))
		else $error("relay moved without cause");
endmodule

bind o2_alarm_range o2_alarm_range_asserts o2_alarm_range_asserts_i (
	.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .sample_i, .conc_i, .dat_o, .ack_o,
	.first_concentration_alarm_relay_o, .conc_volt_o, .conc_curr_o,
	.range_id_volt_o, .range_id_curr_o
);

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
	// design ports
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        ce_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0;
	logic        sample_i = 1'b0;
	logic [15:0] conc_i = 16'h0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        first_concentration_alarm_relay_o;
	logic        second_concentration_alarm_relay_o;
	logic [15:0] conc_volt_o;
	logic [15:0] conc_curr_o;
	logic [15:0] range_id_volt_o;
	logic [15:0] range_id_curr_o;
	// far-side levels and bookkeeping
	logic [1:0]  contact;
	logic [15:0] volt_mv;
	logic [15:0] curr_ua;
	logic [15:0] id_mv;
	logic [15:0] id_ua;
	logic [31:0] rd;
	int          n_errors = 0;
	int          n_compared = 0;

	o2_alarm_range o2_alarm_range_i (
		.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
		.ack_o, .sample_i, .conc_i, .first_concentration_alarm_relay_o,
		.second_concentration_alarm_relay_o, .conc_volt_o, .conc_curr_o,
		.range_id_volt_o, .range_id_curr_o
	);
	o2_output_stage o2_output_stage_i (
		.relay1_i(first_concentration_alarm_relay_o),
		.relay2_i(second_concentration_alarm_relay_o),
		.volt_code_i(conc_volt_o), .curr_code_i(conc_curr_o),
		.id_volt_code_i(range_id_volt_o), .id_curr_code_i(range_id_curr_o),
		.contact_o(contact), .volt_mv_o(volt_mv), .curr_ua_o(curr_ua),
		.id_mv_o(id_mv), .id_ua_o(id_ua)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim();
		if (n_errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		// no cycle count assumed: only the watchdog ends a hang
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		chk("ack", {31'h0, ack_o}, 32'h1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	// relays settle one edge after the sample edge; the task waits two
	task automatic smp(input logic [15:0] c);
		@(posedge clk_i);
		sample_i <= 1'b1;
		conc_i <= c;
		@(posedge clk_i);
		sample_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
	endtask

	task automatic t_reset();
		logic [7:0]  a [6] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h30};
		logic [31:0] e [6] = '{32'h0, 32'h00012648, 32'h251c, 32'h2580, 32'h2648, 32'h0};
		chk("id_ua", {16'h0, id_ua}, 32'd8000);
		wb(1'b1, 8'h30, 32'hffffffff);
		for (int i = 0; i < 6; i++) begin
			wb(1'b0, a[i], 32'h0);
			chk("reg", rd, e[i]);
		end
		// middle bound moved but kept between its neighbours; upper lanes ignored
		wb(1'b1, 8'h10, 32'hffff2594);
		wb(1'b0, 8'h10, 32'h0);
		chk("bound_mid", rd, 32'h2594);
		wb(1'b0, 8'h18, 32'h0);
		chk("status", rd, 32'h40);
	endtask

	task automatic t_auto();
		logic [15:0] c [5] = '{16'h26ac, 16'h26ac, 16'h265c, 16'h2742, 16'h25e4};
		logic [15:0] m [5] = '{16'd500, 16'd750, 16'd750, 16'd750, 16'd500};
		for (int i = 0; i < 5; i++) begin
			smp(c[i]);
			chk("id_mv", {16'h0, id_mv}, {16'h0, m[i]});
			if (i == 2) begin
				chk("volt_mv", {16'h0, volt_mv}, 32'd100);
				chk("curr_ua", {16'h0, curr_ua}, 32'd5600);
			end
			if (i == 3) begin
				chk("volt", {16'h0, conc_volt_o}, 32'hffff);
				wb(1'b0, 8'h1c, 32'h0);
				chk("conc", rd, 32'h2742);
			end
		end
	endtask

	// fixed modes hold even where auto would move
	task automatic t_fixed();
		for (int k = 1; k < 4; k++) begin
			wb(1'b1, 8'h00, 32'(k));
			smp(16'h24b8);
			chk("id_mv", {16'h0, id_mv}, 32'(k * 250));
			chk("id_ua", {16'h0, id_ua}, 32'(4000 + k * 4000));
			chk("volt", {16'h0, conc_volt_o}, 32'h0);
		end
		wb(1'b1, 8'h00, 32'h0);
	endtask

	// a sample offered while the enable is low must leave every output alone
	task automatic t_freeze();
		@(posedge clk_i);
		ce_i <= 1'b0;
		sample_i <= 1'b1;
		conc_i <= 16'h2742;
		@(posedge clk_i);
		ce_i <= 1'b1;
		sample_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		chk("frozen_volt", {16'h0, conc_volt_o}, 32'h0);
		chk("frozen_id", {16'h0, id_mv}, 32'd750);
	endtask

	// alarm1 high 99.00, alarm2 low 97.00 failsafe
	task automatic t_alarm();
		logic [15:0] c [3] = '{16'h26de, 16'h26ac, 16'h2580};
		logic [1:0]  e [3] = '{2'b11, 2'b10, 2'b00};
		wb(1'b1, 8'h04, 32'h000126ac);
		wb(1'b1, 8'h08, 32'h000425e4);
		for (int i = 0; i < 3; i++) begin
			smp(c[i]);
			chk("contacts", {30'h0, contact}, {30'h0, e[i]});
		end
	endtask

	task automatic t_latch();
		wb(1'b1, 8'h04, 32'h000926ac);
		smp(16'h26de);
		smp(16'h2648);
		chk("latched", {31'h0, contact[0]}, 32'h1);
		wb(1'b1, 8'h04, 32'h000b26ac);
		wb(1'b1, 8'h04, 32'h000926ac);
		repeat (4) @(posedge clk_i);
		#1;
		chk("defeat_clr", {31'h0, contact[0]}, 32'h0);
		smp(16'h26de);
		wb(1'b1, 8'h04, 32'h000126ac);
		wb(1'b1, 8'h04, 32'h000926ac);
		repeat (4) @(posedge clk_i);
		#1;
		chk("latch_clr", {31'h0, contact[0]}, 32'h0);
		wb(1'b1, 8'h04, 32'h000b26ac);
		smp(16'h26de);
		chk("defeated", {31'h0, contact[0]}, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// 25 MHz
	initial begin
		forever #20 clk_i = ~clk_i;
	end

	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_auto();
		t_fixed();
		t_freeze();
		t_alarm();
		t_latch();
		end_sim();
	end

	// the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_i);
		n_errors++;
		end_sim();
	end
endmodule
